//--- sfsp_bit_counter.sv
// Bit and frame position counter with boundary alignment
`timescale 1ns/100ps
module sfsp_bit_counter
	import sfsp_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Control
	input  wire logic       step,
	input  wire logic       align,
	input  wire logic       align_mf,
	input  wire logic [7:0] bit_last,
	input  wire logic [4:0] frame_last,
	// Position
	output logic [7:0]      bit_cnt,
	output logic [4:0]      frame_cnt
);

	typedef struct packed {
		logic [7:0] bits;
		logic [4:0] frames;
	} sfsp_cnt_t;

	sfsp_cnt_t st_q;
	sfsp_cnt_t st_d;

	always_comb begin
		st_d = st_q;
		if (step) begin
			if (align) begin
				st_d.bits = 8'h01;
				if (align_mf) begin
					st_d.frames = 5'h00;
				end
			end else if (st_q.bits >= bit_last) begin
				st_d.bits = 8'h00;
				if (st_q.frames >= frame_last) begin
					st_d.frames = 5'h00;
				end else begin
					st_d.frames = st_q.frames + 5'h01;
				end
			end else begin
				st_d.bits = st_q.bits + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign bit_cnt   = st_q.bits;
	assign frame_cnt = st_q.frames;

endmodule : sfsp_bit_counter

//--- sfsp_edge_sync.sv
// Two-stage synchroniser with edge detection for an outside level
`timescale 1ns/100ps
module sfsp_edge_sync
	import sfsp_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Outside level
	input  wire logic pin,
	// Synchronised level and edges
	output logic      level,
	output logic      rise,
	output logic      fall
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sfsp_sync_t;

	sfsp_sync_t st_q;
	sfsp_sync_t st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = pin;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level = st_q.s2;
	assign rise  = st_q.s2 & ~st_q.s3;
	assign fall  = ~st_q.s2 & st_q.s3;

endmodule : sfsp_edge_sync

//--- sfsp_link_model.sv
// Far-end timing logic model: link clocks, serial data and sync pulses
`timescale 1ns/100ps
module sfsp_link_model (
	// Link clocks
	output logic       tx_clock_input,
	output logic       rx_recovered_clock,
	output logic [3:0] pll_rate_clock,
	// Serial data and sync
	output logic       tx_serial_in,
	output logic       tx_sync_drive,
	// Bench control
	input  wire logic  data_bit,
	input  wire logic  sync_req
);
	// Free-running clocks, phases unrelated to the system clock
	initial begin
		tx_clock_input     = 1'b0;
		rx_recovered_clock = 1'b0;
		pll_rate_clock     = 4'h0;
		tx_serial_in       = 1'b0;
		tx_sync_drive      = 1'b0;
		fork
			#13 forever #200 tx_clock_input = ~tx_clock_input;
			#37 forever #200 rx_recovered_clock = ~rx_recovered_clock;
			#7 forever #100 pll_rate_clock = pll_rate_clock + 4'h1;
		join
	end

	// Launch on the rising edge so values are steady at the falling edge
	always @(posedge tx_clock_input) begin
		tx_serial_in  <= data_bit;
		tx_sync_drive <= sync_req;
	end
endmodule : sfsp_link_model

//--- sfsp_pkg.sv
// Constants and register layout of the system port
package sfsp_pkg;

	// Register offsets
	localparam logic [7:0] SFSP_CTRL_ADDR = 8'h00;
	localparam logic [7:0] SFSP_STAT_ADDR = 8'h04;

	// Control register fields
	localparam int SFSP_CTRL_W          = 17;
	localparam int SFSP_F_MODE_LO       = 0;
	localparam int SFSP_F_NRZ           = 2;
	localparam int SFSP_F_CC_BOUND      = 3;
	localparam int SFSP_F_RX_MF         = 4;
	localparam int SFSP_F_RX_DW         = 5;
	localparam int SFSP_F_PAYLOAD       = 6;
	localparam int SFSP_F_TSYNC_OUT     = 7;
	localparam int SFSP_F_TSYNC_MF      = 8;
	localparam int SFSP_F_TX_SRC_RX     = 9;
	localparam int SFSP_F_PLL_BYPASS    = 10;
	localparam int SFSP_F_PLL_RATE_LO   = 11;
	localparam int SFSP_F_PLL_OUT_LO    = 13;
	localparam int SFSP_F_SLOW_EN       = 16;
	localparam logic [16:0] SFSP_CTRL_RESET = 17'h00400;

	// Operating modes
	localparam logic [1:0] SFSP_MODE_T1   = 2'h0;
	localparam logic [1:0] SFSP_MODE_E1   = 2'h1;
	localparam logic [1:0] SFSP_MODE_CC   = 2'h2;
	localparam logic [1:0] SFSP_MODE_6312 = 2'h3;

	// PLL output select value that routes the direct or converted transmit clock, before the source choice
	localparam logic [2:0] SFSP_PLL_OUT_TXCLK = 3'h4;

	// Bit and frame counts, stored as last index; composite high times stored as counts
	localparam logic [7:0] SFSP_T1_BIT_LAST   = 8'hc0;
	localparam logic [4:0] SFSP_T1_FRAME_LAST = 5'h17;
	localparam logic [7:0] SFSP_E1_BIT_LAST   = 8'hff;
	localparam logic [4:0] SFSP_E1_FRAME_LAST = 5'h0f;
	localparam logic [7:0] SFSP_CC_BIT_LAST   = 8'h07;
	localparam logic [4:0] SFSP_CC_FRAME_LAST = 5'h13;
	localparam logic [7:0] SFSP_CC_8K_HIGH    = 8'h04;
	localparam logic [4:0] SFSP_CC_400_HIGH   = 5'h0a;

	// E1 gapped time slots
	localparam logic [7:0] SFSP_E1_TS0_END  = 8'h08;
	localparam logic [7:0] SFSP_E1_TS16_BEG = 8'h80;
	localparam logic [7:0] SFSP_E1_TS16_END = 8'h88;

	// T1 signaling frames, zero based, repeat every six frames
	localparam logic [4:0] SFSP_T1_SIG_A = 5'h05;
	localparam logic [4:0] SFSP_T1_SIG_B = 5'h0b;
	localparam logic [4:0] SFSP_T1_SIG_C = 5'h11;
	localparam logic [4:0] SFSP_T1_SIG_D = 5'h17;

endpackage : sfsp_pkg

//--- sfsp_system_port.sv
// System-side serial port: transmit clock, sync and data, receive clock, sync and data
// Operation
// - PLL output pin carries a selected PLL rate or the direct or converted transmit clock, before the recovered-clock source choice
// - Transmit clock input used directly or via PLL rate conversion
// - Transmit serial data sampled on falling internal transmit clock edge
// - T1/E1 sync input sampled on falling edge sets frame or multiframe boundary
// - T1/E1 sync output updated on rising edge with frame or multiframe pulse
// - Composite sync input sampled on falling edge sets 8kHz or composite_slow_clock_out boundary
// - Composite sync output updated on rising edge shows 8kHz or composite_slow_clock_out alignment
// - Transmit clock output buffers converted PLL rate, transmit input or recovered clock
// - Payload mode gaps transmit clock on T1 F-bit, E1 slots 0 and 16
// - T1/E1 bipolar data outputs updated on rising transmit clock output edge
// - Output format bit puts NRZ data on the positive data output
// - Composite and 6312kHz modes hold both transmit data outputs low
// - Receive clock output carries the recovered clock in every mode
// - Payload mode gaps receive clock on T1 F-bit, E1 slots 0 and 16
// - T1/E1 receive sync pulse one clock wide, frame or multiframe boundary
// - T1 frame sync may be double wide on signaling frames
// - Composite mode receive sync carries 8kHz, 6312kHz mode high impedance
// - Slow clock output carries composite_slow_clock_out in composite mode if enabled, else off
// - Receive serial data NRZ on rising recovered edge, off outside T1/E1
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
module sfsp_system_port
	import sfsp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Transmit pins
	input  wire logic        tx_clock_input,
	input  wire logic [3:0]  pll_rate_clock,
	input  wire logic        tx_serial_in,
	input  wire logic        tx_sync_pin_in,
	output logic             tx_sync_pin_out,
	output logic             tx_sync_pin_oe_n,
	output logic             pll_clock_out,
	output logic             tx_clock_out,
	output logic             tx_positive_out,
	output logic             tx_negative_out,
	// Transmit formatter side
	output logic             tx_data_to_formatter,
	output logic             tx_data_strobe,
	input  wire logic        fmt_positive,
	input  wire logic        fmt_negative,
	input  wire logic        fmt_nrz,
	// Receive side
	input  wire logic        rx_recovered_clock,
	input  wire logic        rx_nrz_in,
	input  wire logic        rx_frame_align,
	input  wire logic        rx_frame_align_mf,
	output logic             rx_clock_out,
	output logic             rx_sync_out,
	output logic             rx_sync_out_oe_n,
	output logic             composite_slow_clock_out,
	output logic             composite_slow_clock_oe_n,
	output logic             rx_serial_out,
	output logic             rx_serial_oe_n
);

	localparam int NPIN = 8;

	typedef struct packed {
		logic [SFSP_CTRL_W-1:0] ctrl;
		logic [31:0]            rdata;
		logic                   tsync_prev;
		logic                   pll_out;
		logic                   tx_clk_o;
		logic                   tx_pos;
		logic                   tx_neg;
		logic                   tx_sync_o;
		logic                   tx_data;
		logic                   tx_strobe;
		logic                   rx_clk_o;
		logic                   rx_ser;
		logic                   rx_sync;
		logic                   slow;
	} sfsp_state_t;

	sfsp_state_t st_q;
	sfsp_state_t st_d;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_lvl;
	logic [NPIN-1:0] pin_rise;
	logic [NPIN-1:0] pin_fall;

	// Pin synchronisers: 0-3 PLL rates, 4 transmit clock, 5 recovered clock, 6 data, 7 sync
	assign pin_raw = {tx_sync_pin_in, tx_serial_in, rx_recovered_clock, tx_clock_input,
		pll_rate_clock};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			sfsp_edge_sync u_sync (
				.clk   (clk),
				.nrst  (nrst),
				.pin   (pin_raw[gi]),
				.level (pin_lvl[gi]),
				.rise  (pin_rise[gi]),
				.fall  (pin_fall[gi])
			);
		end
	endgenerate

	// Control fields
	logic [1:0] mode;
	logic       is_t1;
	logic       is_e1;
	logic       is_cc;
	logic       is_framed;
	logic [1:0] pll_rate;
	logic [2:0] pll_out_sel;

	assign mode        = st_q.ctrl[SFSP_F_MODE_LO +: 2];
	assign is_t1       = (mode == SFSP_MODE_T1);
	assign is_e1       = (mode == SFSP_MODE_E1);
	assign is_cc       = (mode == SFSP_MODE_CC);
	assign is_framed   = is_t1 | is_e1;
	assign pll_rate    = st_q.ctrl[SFSP_F_PLL_RATE_LO +: 2];
	assign pll_out_sel = st_q.ctrl[SFSP_F_PLL_OUT_LO +: 3];

	// Internal transmit clock: direct input or converted rate, then source choice
	logic tint_lvl;
	logic tx_lvl;
	logic tx_rise;
	logic tx_fall;

	always_comb begin
		if (st_q.ctrl[SFSP_F_PLL_BYPASS]) begin
			tint_lvl = pin_lvl[4];
		end else begin
			tint_lvl = pin_lvl[pll_rate];
		end
		if (st_q.ctrl[SFSP_F_TX_SRC_RX]) begin
			tx_lvl  = pin_lvl[5];
			tx_rise = pin_rise[5];
			tx_fall = pin_fall[5];
		end else if (st_q.ctrl[SFSP_F_PLL_BYPASS]) begin
			tx_lvl  = pin_lvl[4];
			tx_rise = pin_rise[4];
			tx_fall = pin_fall[4];
		end else begin
			tx_lvl  = pin_lvl[pll_rate];
			tx_rise = pin_rise[pll_rate];
			tx_fall = pin_fall[pll_rate];
		end
	end

	// Frame geometry per mode
	logic [7:0] bit_last;
	logic [4:0] frame_last;

	always_comb begin
		case (mode)
			SFSP_MODE_T1: begin
				bit_last   = SFSP_T1_BIT_LAST;
				frame_last = SFSP_T1_FRAME_LAST;
			end
			SFSP_MODE_E1: begin
				bit_last   = SFSP_E1_BIT_LAST;
				frame_last = SFSP_E1_FRAME_LAST;
			end
			SFSP_MODE_CC: begin
				bit_last   = SFSP_CC_BIT_LAST;
				frame_last = SFSP_CC_FRAME_LAST;
			end
			default: begin
				bit_last   = SFSP_CC_BIT_LAST;
				frame_last = SFSP_CC_FRAME_LAST;
			end
		endcase
	end

	// Transmit sync input: pulse edge seen at a falling transmit clock edge
	logic tsync_in_mode;
	logic tx_align;
	logic tx_align_mf;

	assign tsync_in_mode = ~st_q.ctrl[SFSP_F_TSYNC_OUT];
	assign tx_align      = tsync_in_mode & pin_lvl[7] & ~st_q.tsync_prev;
	always_comb begin
		if (is_cc) begin
			tx_align_mf = st_q.ctrl[SFSP_F_CC_BOUND];
		end else begin
			tx_align_mf = st_q.ctrl[SFSP_F_TSYNC_MF];
		end
	end

	logic [7:0] tx_bit;
	logic [4:0] tx_frame;
	logic [7:0] rx_bit;
	logic [4:0] rx_frame;

	sfsp_bit_counter u_tx_cnt (
		.clk        (clk),
		.nrst       (nrst),
		.step       (tx_fall),
		.align      (tx_align),
		.align_mf   (tx_align_mf),
		.bit_last   (bit_last),
		.frame_last (frame_last),
		.bit_cnt    (tx_bit),
		.frame_cnt  (tx_frame)
	);

	sfsp_bit_counter u_rx_cnt (
		.clk        (clk),
		.nrst       (nrst),
		.step       (pin_fall[5]),
		.align      (rx_frame_align),
		.align_mf   (rx_frame_align_mf),
		.bit_last   (bit_last),
		.frame_last (frame_last),
		.bit_cnt    (rx_bit),
		.frame_cnt  (rx_frame)
	);

	// Payload gaps on F-bit or E1 slots 0 and 16
	function automatic logic sfsp_gap(input logic t1, input logic e1, input logic [7:0] b);
		logic g;
		g = 1'b0;
		if (t1) begin
			g = (b == 8'h00);
		end else if (e1) begin
			g = (b < SFSP_E1_TS0_END) || (b >= SFSP_E1_TS16_BEG && b < SFSP_E1_TS16_END);
		end
		return g;
	endfunction : sfsp_gap

	logic tx_gap;
	logic rx_gap;
	logic rx_sig_frame;

	assign tx_gap = st_q.ctrl[SFSP_F_PAYLOAD] & sfsp_gap(is_t1, is_e1, tx_bit);
	assign rx_gap = st_q.ctrl[SFSP_F_PAYLOAD] & sfsp_gap(is_t1, is_e1, rx_bit);
	assign rx_sig_frame = (rx_frame == SFSP_T1_SIG_A) || (rx_frame == SFSP_T1_SIG_B) ||
		(rx_frame == SFSP_T1_SIG_C) || (rx_frame == SFSP_T1_SIG_D);

	always_comb begin
		st_d = st_q;
		// Register port
		st_d.rdata = 32'h0000_0000;
		if (reg_wr && reg_addr == SFSP_CTRL_ADDR) begin
			st_d.ctrl = reg_wdata[SFSP_CTRL_W-1:0];
		end
		if (reg_rd) begin
			case (reg_addr)
				SFSP_CTRL_ADDR: st_d.rdata = {15'h0000, st_q.ctrl};
				SFSP_STAT_ADDR: st_d.rdata = {3'h0, rx_frame, rx_bit, 3'h0, tx_frame, tx_bit};
				default:        st_d.rdata = 32'h0000_0000;
			endcase
		end
		// PLL output pin
		if (pll_out_sel == SFSP_PLL_OUT_TXCLK) begin
			st_d.pll_out = tint_lvl;
		end else begin
			st_d.pll_out = pin_lvl[pll_out_sel[1:0]];
		end
		// Transmit clock output, gapped in payload mode
		st_d.tx_clk_o  = tx_lvl & ~tx_gap;
		// Transmit data sampled at the falling edge
		st_d.tx_strobe = tx_fall;
		if (tx_fall) begin
			st_d.tx_data    = pin_lvl[6];
			st_d.tsync_prev = pin_lvl[7];
		end
		// Transmit line data and sync output at the rising edge
		if (!is_framed) begin
			st_d.tx_pos = 1'b0;
			st_d.tx_neg = 1'b0;
		end else if (tx_rise && !tx_gap) begin
			st_d.tx_pos = st_q.ctrl[SFSP_F_NRZ] ? fmt_nrz : fmt_positive;
			st_d.tx_neg = fmt_negative;
		end
		if (tx_rise) begin
			if (is_cc) begin
				st_d.tx_sync_o = (tx_bit == 8'h00) &&
					(!st_q.ctrl[SFSP_F_CC_BOUND] || tx_frame == 5'h00);
			end else if (is_framed) begin
				st_d.tx_sync_o = (tx_bit == 8'h00) &&
					(!st_q.ctrl[SFSP_F_TSYNC_MF] || tx_frame == 5'h00);
			end else begin
				st_d.tx_sync_o = 1'b0;
			end
		end
		// Receive clock output, gapped in payload mode
		st_d.rx_clk_o = pin_lvl[5] & ~rx_gap;
		// Receive data, sync and slow clock at the rising recovered edge
		if (pin_rise[5]) begin
			st_d.rx_ser = is_framed ? rx_nrz_in : 1'b0;
			if (is_framed) begin
				st_d.rx_sync = ((rx_bit == 8'h00) &&
					(!st_q.ctrl[SFSP_F_RX_MF] || rx_frame == 5'h00)) ||
					(is_t1 && !st_q.ctrl[SFSP_F_RX_MF] && st_q.ctrl[SFSP_F_RX_DW] &&
					rx_sig_frame && rx_bit == 8'h01);
			end else if (is_cc) begin
				st_d.rx_sync = (rx_bit < SFSP_CC_8K_HIGH);
			end else begin
				st_d.rx_sync = 1'b0;
			end
			st_d.slow = is_cc && st_q.ctrl[SFSP_F_SLOW_EN] &&
				(rx_frame < SFSP_CC_400_HIGH);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q      <= '0;
			st_q.ctrl <= SFSP_CTRL_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs
	assign reg_rdata                 = st_q.rdata;
	assign pll_clock_out             = st_q.pll_out;
	assign tx_clock_out              = st_q.tx_clk_o;
	assign tx_positive_out           = st_q.tx_pos;
	assign tx_negative_out           = st_q.tx_neg;
	assign tx_sync_pin_out           = st_q.tx_sync_o;
	assign tx_sync_pin_oe_n          = tsync_in_mode | ~(is_framed | is_cc);
	assign tx_data_to_formatter      = st_q.tx_data;
	assign tx_data_strobe            = st_q.tx_strobe;
	assign rx_clock_out              = st_q.rx_clk_o;
	assign rx_sync_out               = st_q.rx_sync;
	assign rx_sync_out_oe_n          = (mode == SFSP_MODE_6312);
	assign composite_slow_clock_out  = st_q.slow;
	assign composite_slow_clock_oe_n = ~(is_cc & st_q.ctrl[SFSP_F_SLOW_EN]);
	assign rx_serial_out             = st_q.rx_ser;
	assign rx_serial_oe_n            = ~is_framed;

endmodule : sfsp_system_port

//--- sfsp_system_port_asserts.sv
// Assertion checker for the system port, bound to its top module
`timescale 1ns/100ps
module sfsp_system_port_asserts
	import sfsp_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	// Watched outputs
	input wire logic        tx_clock_out,
	input wire logic        tx_positive_out,
	input wire logic        tx_negative_out,
	input wire logic        tx_sync_pin_oe_n,
	input wire logic        rx_sync_out,
	input wire logic        rx_sync_out_oe_n,
	input wire logic        composite_slow_clock_oe_n,
	input wire logic        rx_serial_oe_n
);
	logic [16:0] ctrl_q;
	logic [4:0]  age_q;
	logic        settled;
	logic [1:0]  mode;

	// Shadow of the control register and cycles since it was last written, held at 31
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= SFSP_CTRL_RESET;
			age_q  <= 5'h00;
		end else if (reg_wr && reg_addr == SFSP_CTRL_ADDR) begin
			ctrl_q <= reg_wdata[16:0];
			age_q  <= 5'h00;
		end else if (age_q != 5'h1f) begin
			age_q <= age_q + 5'h01;
		end
	end
	assign settled = age_q == 5'h1f;
	assign mode    = ctrl_q[1:0];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	AST_LINE_LOW: assert property (settled && mode[1] |-> !tx_positive_out && !tx_negative_out)
		else $error("line data not low");
	AST_SLOW_OFF: assert property (settled && mode != SFSP_MODE_CC |-> composite_slow_clock_oe_n)
		else $error("slow clock driven outside composite mode");
	AST_SLOW_ON: assert property (settled && mode == SFSP_MODE_CC && ctrl_q[SFSP_F_SLOW_EN]
		|-> !composite_slow_clock_oe_n) else $error("slow clock not driven");
	AST_RX_SERIAL_OUT_OE: assert property (settled |-> rx_serial_oe_n == mode[1])
		else $error("receive data enable wrong");
	AST_RSYNC_OE: assert property (settled |-> rx_sync_out_oe_n == (mode == SFSP_MODE_6312))
		else $error("receive sync enable wrong");
	AST_TSYNC_OE: assert property (settled && !mode[1]
		|-> tx_sync_pin_oe_n == !ctrl_q[SFSP_F_TSYNC_OUT]) else $error("sync pin direction wrong");
	AST_RSYNC_WIDTH: assert property (disable iff (!nrst || reg_wr)
		settled && !mode[1] && !ctrl_q[SFSP_F_RX_DW]
		&& $rose(rx_sync_out) |-> rx_sync_out[*8] ##1 !rx_sync_out) else $error("sync width wrong");
	AST_TXDATA_EDGE: assert property (settled && !mode[1] && $changed(tx_positive_out)
		|-> $rose(tx_clock_out)) else $error("line data moved off clock edge");

	cover property ($rose(rx_sync_out));
	cover property ($fell(composite_slow_clock_oe_n));
	cover property ($rose(tx_clock_out) && tx_positive_out);
endmodule : sfsp_system_port_asserts

bind sfsp_system_port sfsp_system_port_asserts u_asserts (.*);

//--- sfsp_system_port_tb.sv
// Self-checking testbench of the system port with far-end model
`timescale 1ns/100ps
module sfsp_system_port_tb
	import sfsp_pkg::*;
;
	logic        clk, nrst, reg_wr, reg_rd;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, stat;
	logic [3:0]  pll_rate_clock;
	logic        tx_clock_input, tx_serial_in, tx_sync_pin_in, tx_sync_drive;
	logic        tx_sync_pin_out, tx_sync_pin_oe_n, pll_clock_out, tx_clock_out;
	logic        tx_positive_out, tx_negative_out, tx_data_to_formatter, tx_data_strobe;
	logic        fmt_positive, fmt_negative, fmt_nrz, data_bit, sync_req, rx_align;
	logic        rx_recovered_clock, rx_nrz_in, rx_clock_out, rx_sync_out, rx_sync_out_oe_n;
	logic        composite_slow_clock_out, composite_slow_clock_oe_n, rx_serial_out, rx_serial_oe_n;
	int          miscompares, check_count, highs;
	int          rises[6];

	// Shared sync pin level
	assign tx_sync_pin_in = tx_sync_pin_oe_n ? tx_sync_drive : tx_sync_pin_out;

	sfsp_system_port DUT (.rx_frame_align(rx_align), .rx_frame_align_mf(rx_align), .*);
	sfsp_link_model u_far (.*);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		stat = reg_rdata;
	endtask : rd

	task automatic cfg(input logic [31:0] v);
		wr(SFSP_CTRL_ADDR, v);
		repeat (48) @(posedge clk);
		#1;
	endtask : cfg

	function automatic logic [5:0] pins();
		return {tx_sync_pin_out, composite_slow_clock_out, rx_sync_out,
			pll_clock_out, rx_clock_out, tx_clock_out};
	endfunction : pins

	// Counts rising edges of the watched outputs and receive sync high cycles
	task automatic watch(input int n);
		logic [5:0] was, now;
		rises = '{default: 0};
		highs = 0;
		was = pins();
		repeat (n) begin
			@(posedge clk);
			#1;
			now = pins();
			highs += int'(now[3]);
			for (int i = 0; i < 6; i++) rises[i] += int'(now[i] && !was[i]);
			was = now;
		end
	endtask : watch

	task automatic strobe(input int n);
		int t;
		t = 0;
		while (n > 0 && t < 100) begin
			@(posedge clk);
			#1;
			t++;
			if (tx_data_strobe === 1'b1) n--;
		end
		check("strobe", n, 0);
	endtask : strobe

	// One transmit sync pulse and one receive alignment, then status read
	task automatic tsync_pulse();
		@(posedge clk);
		sync_req <= 1'b1;
		rx_align <= 1'b1;
		repeat (8) @(posedge clk);
		sync_req <= 1'b0;
		rx_align <= 1'b0;
		repeat (24) @(posedge clk);
		rd(SFSP_STAT_ADDR);
	endtask : tsync_pulse

	// Hang guard
	initial begin
		#5000000;
		miscompares++;
		stop_test();
	end

	initial begin
		{nrst, reg_wr, reg_rd, fmt_positive, data_bit, sync_req, rx_align} = '0;
		{fmt_negative, rx_nrz_in, fmt_nrz} = 3'b111;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd(SFSP_CTRL_ADDR);
		check("ctrl reset", stat, {15'h0, SFSP_CTRL_RESET});
		wr(SFSP_CTRL_ADDR, 32'hffffffff);
		rd(SFSP_CTRL_ADDR);
		check("ctrl width", stat, 32'h0001ffff);
		rd(8'h08);
		check("unmapped", stat, 32'h0);
		$display("test registers done");
		cfg(32'h8400);
		watch(80);
		check("tx clock", rises[0], 10);
		check("rx clock", rises[1], 10);
		check("pll txclk", rises[2], 10);
		cfg(32'h7000);
		watch(160);
		check("tx clock pll", rises[0], 10);
		check("pll rate", rises[2], 5);
		cfg(32'h1200);
		watch(160);
		check("tx clock rx", rises[0], 20);
		$display("test clocks done");
		cfg(32'h04c0);
		watch(1544);
		check("t1 tx gap", rises[0], 192);
		check("t1 rx gap", rises[1], 192);
		check("t1 rsync", rises[3], 1);
		check("t1 rsync width", highs, 8);
		check("t1 tsync", rises[5], 1);
		cfg(32'h04c1);
		watch(2048);
		check("e1 tx gap", rises[0], 240);
		check("e1 rx gap", rises[1], 240);
		check("e1 rsync", rises[3], 1);
		check("e1 tsync", rises[5], 1);
		cfg(32'h0590);
		watch(37056);
		check("t1 mf sync", rises[3], 1);
		check("t1 mf tsync", rises[5], 1);
		cfg(32'h0420);
		watch(9264);
		check("t1 dw width", highs, 56);
		$display("test framing done");
		for (int m = 0; m < 4; m++) begin
			cfg(32'h0404 | m);
			check("pos nrz", tx_positive_out, m < 2);
			check("neg", tx_negative_out, m < 2);
			check("rx_serial_out oe", rx_serial_oe_n, m > 1);
			check("rsync oe", rx_sync_out_oe_n, m == 3);
			@(posedge clk);
			fmt_nrz <= 1'b0;
			repeat (16) @(posedge clk);
			fmt_nrz <= 1'b1;
			#1;
			check("pos nrz low", tx_positive_out, 0);
		end
		cfg(32'h0400);
		check("pos bipolar", tx_positive_out, 0);
		check("rx_serial_out", rx_serial_out, 1);
		$display("test line data done");
		cfg(32'h10482);
		watch(1280);
		check("cc 8k", rises[3], 20);
		check("cc 8k width", highs, 640);
		check("cc 400", rises[4], 1);
		check("cc tsync 8k", rises[5], 20);
		cfg(32'h1048a);
		watch(1280);
		check("cc tsync 400", rises[5], 1);
		cfg(32'h0403);
		check("6312 slow oe", composite_slow_clock_oe_n, 1);
		$display("test composite done");
		cfg(32'h0500);
		data_bit = 1'b1;
		strobe(2);
		check("tx data one", tx_data_to_formatter, 1);
		data_bit = 1'b0;
		strobe(2);
		check("tx data zero", tx_data_to_formatter, 0);
		tsync_pulse();
		check("tx bit aligned", stat[7:0] < 8'h06, 1);
		check("tx frame aligned", stat[12:8], 0);
		check("rx bit aligned", stat[23:16] < 8'h06, 1);
		check("rx frame aligned", stat[28:24], 0);
		cfg(32'h1040a);
		tsync_pulse();
		check("cc bit aligned", stat[7:0] < 8'h06, 1);
		check("cc 400 aligned", stat[12:8], 0);
		$display("test transmit sampling done");
		stop_test();
	end
endmodule : sfsp_system_port_tb
